// ---- pgd_power_good.sv ----
// Notes on behaviour
// - Unmasked event pulls output low after delay.
// - Output released after release delay when clear.
// - Bits 7,6 mask output overvoltage fault, warning.
// - Bits 5,4 mask output undervoltage fault, warning.
// - Bits 3,2 mask overcurrent warning, fault.
// - Bits 1,0 mask input overvoltage warning, fault.
// - Low when disabled, ramping, or fault shutdown.
// - Fall ramp or shutdown bypasses assert delay.
// - Only faults, not warnings, are ignored when response continues.
// - Assert and release timers run independently.
// - Events shorter than the assert delay are hidden.
// - Host writes accepted only while conversion disabled; NVM load always writes.
`timescale 1ns/10ps
`default_nettype none
module pgd_power_good
    import pgd_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic i_pwm_tick,
    input wire pgd_event_type i_event,
    input wire pgd_event_type i_continue,
    input wire pgd_phase_type i_phase,
    input wire logic i_nvm_load,
    input wire logic [15:0] i_nvm_data,
    input wire logic i_cfg_wr,
    input wire logic [7:0] i_cfg_cmd,
    input wire logic [15:0] i_cfg_wdata,
    output logic [15:0] O_CFG_RDATA,
    output logic O_CFG_WR_REJECT,
    output logic O_POWER_OK
);

    // ----------------------------------------------------------------
    // Configuration word
    // ----------------------------------------------------------------
    logic [15:0] cfg_q;
    logic [15:0] cfg_d;
    logic reject_d;
    logic reject_q;

    always_comb begin
        cfg_d = cfg_q;
        reject_d = 1'b0;
        if (i_nvm_load) begin
            cfg_d = i_nvm_data;
        end else if (i_cfg_wr && i_cfg_cmd == PGD_CFG_OFFSET) begin
            // Writes while converting are dropped and flagged so the host sees it.
            if (i_phase.conv_enabled) begin
                reject_d = 1'b1;
            end else begin
                cfg_d = i_cfg_wdata;
            end
        end
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            cfg_q <= PGD_CFG_RESET;
            reject_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            reject_q <= reject_d;
        end
    end

    // ----------------------------------------------------------------
    // Event qualification
    // ----------------------------------------------------------------
    logic [3:0] assert_delay_code;
    logic [3:0] release_delay_code;
    logic mask_out_overvolt_fault;
    logic mask_out_overvolt_warn;
    logic mask_out_undervolt_fault;
    logic mask_out_undervolt_warn;
    logic mask_out_overcurrent_warn;
    logic mask_out_overcurrent_fault;
    logic mask_in_overvolt_warn;
    logic mask_in_overvolt_fault;
    pgd_event_type live;
    logic unmasked;
    logic forced_low;
    logic bypass;

    assign assert_delay_code = cfg_q[PGD_ASSERT_MSB:PGD_ASSERT_LSB];
    assign release_delay_code = cfg_q[PGD_RELEASE_MSB:PGD_RELEASE_LSB];
    assign mask_out_overvolt_fault = cfg_q[PGD_MASK_OVF];
    assign mask_out_overvolt_warn = cfg_q[PGD_MASK_OVW];
    assign mask_out_undervolt_fault = cfg_q[PGD_MASK_UVF];
    assign mask_out_undervolt_warn = cfg_q[PGD_MASK_UVW];
    assign mask_out_overcurrent_warn = cfg_q[PGD_MASK_OCW];
    assign mask_out_overcurrent_fault = cfg_q[PGD_MASK_OCF];
    assign mask_in_overvolt_warn = cfg_q[PGD_MASK_INOVW];
    assign mask_in_overvolt_fault = cfg_q[PGD_MASK_INOVF];

    always_comb begin
        // Warnings have no response setting; only faults may be told to ride through.
        live = i_event;
        live.out_overvolt_fault = i_event.out_overvolt_fault & ~i_continue.out_overvolt_fault;
        live.out_undervolt_fault = i_event.out_undervolt_fault & ~i_continue.out_undervolt_fault;
        live.out_overcurrent_fault = i_event.out_overcurrent_fault & ~i_continue.out_overcurrent_fault;
        live.in_overvolt_fault = i_event.in_overvolt_fault & ~i_continue.in_overvolt_fault;
        unmasked = (live.out_overvolt_fault & ~mask_out_overvolt_fault)
            | (live.out_overvolt_warn & ~mask_out_overvolt_warn)
            | (live.out_undervolt_fault & ~mask_out_undervolt_fault)
            | (live.out_undervolt_warn & ~mask_out_undervolt_warn)
            | (live.out_overcurrent_warn & ~mask_out_overcurrent_warn)
            | (live.out_overcurrent_fault & ~mask_out_overcurrent_fault)
            | (live.in_overvolt_warn & ~mask_in_overvolt_warn)
            | (live.in_overvolt_fault & ~mask_in_overvolt_fault);
        forced_low = ~i_phase.conv_enabled | i_phase.ton_delay | i_phase.ton_rise
            | i_phase.toff_fall | i_phase.fault_shutdown;
        bypass = i_phase.toff_fall | i_phase.fault_shutdown;
    end

    // ----------------------------------------------------------------
    // Delay timers
    // ----------------------------------------------------------------
    logic assert_done;
    logic release_done;
    pgd_state_type state_q;
    pgd_state_type state_d;
    logic power_ok_d;
    logic power_ok_q;

    // Each timer watches only its own condition, so a short event never reaches
    // the assert count while the release side stays idle.
    pgd_timer u_assert_timer (
        .i_clk(I_CLK),
        .i_rst(I_SYS_RST),
        .i_pwm_tick(i_pwm_tick),
        .i_arm(state_q == PGD_HIGH && unmasked),
        .i_code(assert_delay_code),
        .o_done(assert_done)
    );

    pgd_timer u_release_timer (
        .i_clk(I_CLK),
        .i_rst(I_SYS_RST),
        .i_pwm_tick(i_pwm_tick),
        .i_arm(state_q == PGD_LOW && !unmasked && !forced_low),
        .i_code(release_delay_code),
        .o_done(release_done)
    );

    // ----------------------------------------------------------------
    // Output state
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            PGD_HIGH: begin
                if (forced_low || (bypass && unmasked) || assert_done) begin
                    state_d = PGD_LOW;
                end
            end
            PGD_LOW: begin
                // A phase or event that arrives on the done cycle must win, or the output would blip high.
                if (release_done && !forced_low && !unmasked) begin
                    state_d = PGD_HIGH;
                end
            end
            default: begin
                state_d = PGD_LOW;
            end
        endcase
        power_ok_d = (state_d == PGD_HIGH);
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            state_q <= PGD_LOW;
            power_ok_q <= 1'b0;
        end else begin
            state_q <= state_d;
            power_ok_q <= power_ok_d;
        end
    end

    // Read data is registered so the bus sees a stable word for a whole cycle.
    logic [15:0] rdata_q;
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            rdata_q <= PGD_CFG_RESET;
        end else begin
            rdata_q <= cfg_q;
        end
    end

    assign O_CFG_RDATA = rdata_q;
    assign O_CFG_WR_REJECT = reject_q;
    assign O_POWER_OK = power_ok_q;
endmodule
`default_nettype wire

// ---- pgd_pkg.sv ----
package pgd_pkg;

    // ----------------------------------------------------------------
    // Configuration word layout
    // ----------------------------------------------------------------
    localparam logic [7:0] PGD_CFG_OFFSET = 8'he3;
    localparam int PGD_ASSERT_MSB = 15;
    localparam int PGD_ASSERT_LSB = 12;
    localparam int PGD_RELEASE_MSB = 11;
    localparam int PGD_RELEASE_LSB = 8;
    localparam int PGD_MASK_OVF = 7;
    localparam int PGD_MASK_OVW = 6;
    localparam int PGD_MASK_UVF = 5;
    localparam int PGD_MASK_UVW = 4;
    localparam int PGD_MASK_OCW = 3;
    localparam int PGD_MASK_OCF = 2;
    localparam int PGD_MASK_INOVW = 1;
    localparam int PGD_MASK_INOVF = 0;
    localparam logic [15:0] PGD_CFG_RESET = 16'h0000;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int PGD_CNT_W = 17;
    localparam logic [16:0] PGD_CNT_ZERO = 17'h00000;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic out_overvolt_fault;
        logic out_overvolt_warn;
        logic out_undervolt_fault;
        logic out_undervolt_warn;
        logic out_overcurrent_warn;
        logic out_overcurrent_fault;
        logic in_overvolt_warn;
        logic in_overvolt_fault;
    } pgd_event_type;

    typedef struct packed {
        logic conv_enabled;
        logic ton_delay;
        logic ton_rise;
        logic toff_fall;
        logic fault_shutdown;
    } pgd_phase_type;

    typedef enum logic [1:0] {
        PGD_LOW,
        PGD_HIGH
    } pgd_state_type;

    // Clocks in a delay code: zero gives 1, N gives 2^N + 1.
    function automatic logic [16:0] pgd_delay_clocks(input logic [3:0] code);
        logic [16:0] v;
        v = 17'h00001;
        if (code != 4'h0) begin
            v = (17'h00001 << code) + 17'h00001;
        end
        return v;
    endfunction

endpackage

// ---- pgd_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
module pgd_timer
    import pgd_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_pwm_tick,
    input wire logic i_arm,
    input wire logic [3:0] i_code,
    output logic o_done
);
    logic [16:0] cnt_q;
    logic [16:0] cnt_d;
    logic done_d;
    logic done_q;

    // Counts PWM clocks while armed; disarming clears it so each arming times afresh.
    always_comb begin
        cnt_d = cnt_q;
        done_d = done_q;
        if (!i_arm) begin
            cnt_d = PGD_CNT_ZERO;
            done_d = 1'b0;
        end else if (i_pwm_tick && !done_q) begin
            cnt_d = cnt_q + 17'h00001;
            done_d = (cnt_q + 17'h00001) >= pgd_delay_clocks(i_code);
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q <= PGD_CNT_ZERO;
            done_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            done_q <= done_d;
        end
    end

    assign o_done = done_q;
endmodule
`default_nettype wire

// ---- pgd_power_good_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module pgd_power_good_checker
    import pgd_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire pgd_event_type i_event,
    input wire pgd_event_type i_continue,
    input wire pgd_phase_type i_phase,
    input wire logic i_nvm_load,
    input wire logic i_cfg_wr,
    input wire logic [7:0] i_cfg_cmd,
    input wire logic [15:0] O_CFG_RDATA,
    input wire logic O_CFG_WR_REJECT,
    input wire logic O_POWER_OK
);
    // --------
    // Checks
    // --------
    logic forced;
    logic cause;
    logic quiet;
    logic refuse;
    assign forced = !i_phase.conv_enabled || i_phase.ton_delay || i_phase.ton_rise || i_phase.toff_fall
        || i_phase.fault_shutdown;
    assign cause = forced || (|i_event);
    // Continuing faults and masked events give no reason to drop the output.
    assign quiet = !forced && ((i_event & ~(i_continue & 8'ha5) & ~O_CFG_RDATA[7:0]) == 8'h00);
    assign refuse = i_cfg_wr && i_cfg_cmd == PGD_CFG_OFFSET && i_phase.conv_enabled && !i_nvm_load;
    default clocking @(posedge I_CLK);
    endclocking
    default disable iff (I_SYS_RST);
    reset_clear_a: assert property (
        disable iff (1'b0) I_SYS_RST |=> !O_POWER_OK && O_CFG_RDATA == 16'h0000) else $error("reset not clear");
    reject_write_a: assert property (
        refuse |=> O_CFG_WR_REJECT) else $error("write not refused");
    reject_cause_a: assert property (
        O_CFG_WR_REJECT |-> $past(refuse)) else $error("reject without cause");
    config_locked_a: assert property (
        (i_phase.conv_enabled && !i_nvm_load)[*3] |-> $stable(O_CFG_RDATA)) else $error("config changed");
    forced_low_a: assert property (
        forced[*3] |-> !O_POWER_OK) else $error("high in forced phase");
    rise_clean_a: assert property (
        $rose(O_POWER_OK) |-> !$past(forced, 2)) else $error("rise while forced");
    fall_cause_a: assert property (
        $fell(O_POWER_OK) |-> $past(cause) || $past(cause, 2) || $past(cause, 3)) else $error("fall without cause");
    quiet_hold_a: assert property (
        O_POWER_OK && quiet && $past(quiet) && $past(quiet, 2) |=> O_POWER_OK) else $error("dropped on masked");
endmodule
bind pgd_power_good pgd_power_good_checker pgd_power_good_checker_inst (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST),
    .i_event(i_event), .i_continue(i_continue), .i_phase(i_phase), .i_nvm_load(i_nvm_load), .i_cfg_wr(i_cfg_wr),
    .i_cfg_cmd(i_cfg_cmd), .O_CFG_RDATA(O_CFG_RDATA), .O_CFG_WR_REJECT(O_CFG_WR_REJECT), .O_POWER_OK(O_POWER_OK));
`default_nettype wire

// ---- pgd_supervisor.sv ----
`timescale 1ns/10ps
`default_nettype none
module pgd_supervisor (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_power_ok,
    output logic [15:0] o_fall_count
);
    // --------
    // Supervisor counting every drop of power good it senses.
    // --------
    logic seen_q;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            seen_q <= 1'b0;
            o_fall_count <= 16'h0000;
        end else begin
            seen_q <= i_power_ok;
            if (seen_q && !i_power_ok) begin
                o_fall_count <= o_fall_count + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// ---- pgd_power_good_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; $display("BAD %s %h %h", n, e, g); end end
module pgd_power_good_tb_top
    import pgd_pkg::*;
;
    // --------
    // Bench
    // --------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic tick = 1'b0;
    logic [1:0] tcnt = 2'h0;
    pgd_event_type ev = '0;
    pgd_event_type cont = '0;
    pgd_phase_type ph = '0;
    logic nvm_ld = 1'b0;
    logic [15:0] nvm_d = 16'h0000;
    logic wr = 1'b0;
    logic [7:0] cmd = 8'h00;
    logic [15:0] wd = 16'h0000;
    logic [15:0] rdata;
    logic rej;
    logic pok;
    logic [15:0] falls;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    pgd_power_good pgd_power_good_inst (.I_CLK(clk), .I_SYS_RST(rst), .i_pwm_tick(tick), .i_event(ev),
        .i_continue(cont), .i_phase(ph), .i_nvm_load(nvm_ld), .i_nvm_data(nvm_d), .i_cfg_wr(wr), .i_cfg_cmd(cmd),
        .i_cfg_wdata(wd), .O_CFG_RDATA(rdata), .O_CFG_WR_REJECT(rej), .O_POWER_OK(pok));
    pgd_supervisor pgd_supervisor_inst (.i_clk(clk), .i_rst(rst), .i_power_ok(pok), .o_fall_count(falls));
    always #20 clk = ~clk;
    // Ticks every fourth clock so that an early or late drop shows as a cycle count.
    always @(posedge clk) begin
        tcnt <= tcnt + 2'h1;
        tick <= (tcnt == 2'h3);
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            print_verdict();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wait_pok(input logic v, input int lo, input int hi, input string n);
        int k;
        k = 0;
        while (pok !== v && k <= hi) begin
            step(1);
            k++;
        end
        `CHK(n, 1'b1, k >= lo && k <= hi)
    endtask
    task automatic hold_pok(input logic v, input int n, input string s);
        logic bad;
        bad = 1'b0;
        repeat (n) begin
            step(1);
            bad |= (pok !== v);
        end
        `CHK(s, 1'b0, bad)
    endtask
    task automatic wr_cfg(input logic [7:0] c, input logic [15:0] d, output logic r);
        @(posedge clk);
        wr <= 1'b1;
        cmd <= c;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1 r = rej;
        step(1);
        r |= rej;
        step(1);
    endtask
    task automatic t_config();
        logic r;
        `CHK("rst_pok", 1'b0, pok)
        @(posedge clk);
        nvm_d <= 16'h21ff;
        nvm_ld <= 1'b1;
        @(posedge clk);
        nvm_ld <= 1'b0;
        step(2);
        `CHK("nvm", 16'h21ff, rdata)
        wr_cfg(8'he3, 16'h2100, r);
        `CHK("wr", 16'h2100, r ? 16'hxxxx : rdata)
        wr_cfg(8'he4, 16'h1234, r);
        `CHK("other", 16'h2100, rdata)
    endtask
    task automatic t_powerup();
        logic r;
        @(posedge clk);
        ph.conv_enabled <= 1'b1;
        ph.ton_delay <= 1'b1;
        hold_pok(1'b0, 20, "delay");
        @(posedge clk);
        ph.ton_delay <= 1'b0;
        ph.ton_rise <= 1'b1;
        hold_pok(1'b0, 40, "ramp");
        wr_cfg(8'he3, 16'hffff, r);
        `CHK("locked", 17'h12100, {r, rdata})
        @(posedge clk);
        ph.ton_rise <= 1'b0;
        wait_pok(1'b1, 9, 40, "up");
    endtask
    task automatic t_events();
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            ev <= pgd_event_type'(8'h01 << i);
            wait_pok(1'b0, 17, 40, "assert");
            @(posedge clk);
            ev <= '0;
            wait_pok(1'b1, 9, 40, "release");
        end
        @(posedge clk);
        ev.out_overvolt_warn <= 1'b1;
        repeat (4) @(posedge clk);
        ev <= '0;
        hold_pok(1'b1, 40, "short");
        @(posedge clk);
        cont <= pgd_event_type'(8'ha5);
        ev <= pgd_event_type'(8'ha5);
        hold_pok(1'b1, 40, "continue");
        @(posedge clk);
        cont <= '0;
        ev <= '0;
    endtask
    task automatic t_bypass();
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            ph.toff_fall <= (i == 0);
            ph.fault_shutdown <= (i == 1);
            ev.out_overvolt_fault <= 1'b1;
            wait_pok(1'b0, 0, 3, "bypass");
            @(posedge clk);
            ph.toff_fall <= 1'b0;
            ph.fault_shutdown <= 1'b0;
            ev <= '0;
            wait_pok(1'b1, 9, 40, "back");
        end
    endtask
    task automatic t_masked();
        logic r;
        logic [15:0] f;
        @(posedge clk);
        ph.conv_enabled <= 1'b0;
        wait_pok(1'b0, 0, 3, "off");
        wr_cfg(8'he3, 16'h21ff, r);
        @(posedge clk);
        ph.conv_enabled <= 1'b1;
        wait_pok(1'b1, 9, 40, "on");
        f = falls;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            ev <= pgd_event_type'(8'h01 << i);
            hold_pok(1'b1, 30, "masked");
        end
        `CHK("falls", f, falls)
    endtask
    task automatic print_verdict();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        step(1);
        t_config();
        t_powerup();
        t_events();
        t_bypass();
        t_masked();
        print_verdict();
    end
endmodule
`default_nettype wire
